// ---- verilog/pll_synth_divider_core.v ----
// Notes on behaviour
// - RF divider is 16*M+A, 16/17 stage, 4-bit A, 13-bit M.
// - Prescaler off: overall ratios 240 to 131071.
// - Prescaler on: halving stage first, ratios 480 to 262142.
// - Prescaler off: RF edges go straight into the divider.
// - Reference divider gives comparison rate, fifteen ratios.
// - Reference comes from crystal oscillator or external source.
// - Phase/frequency compare of divider against comparison; pulses drive pump.
// - Test function can switch varactor drive off.
// - Test function can put charge pump output in high impedance.
// - Test function routes halved divider output onto switch port zero.
// - Prescaler enable bit one selects halving, zero bypasses it.
// - Test mode when ref output off and select on; three bits choose.
// - Ratio codes: below 1000 give 2..256, 1000 forbidden, above give 6..384.
//
// Decided for this implementation: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
module pll_synth_divider_core (
    // Clock and reset
    input wire sys_clk_in,
    input wire rstn_in,
    // Wishbone slave
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire [7:0] wb_adr_in,
    input wire [3:0] wb_sel_in,
    input wire [31:0] wb_dat_in,
    output reg [31:0] wb_dat_out,
    output reg wb_ack_out,
    // Asynchronous clock pins
    input wire rf_in,
    input wire xtal_osc_in,
    input wire ext_ref_in,
    // Charge pump pin, three-state
    output reg pump_up_out,
    output reg pump_down_out,
    output reg pump_oe_out,
    // Loop amplifier and outputs
    output reg varactor_drive_on_out,
    output reg ref_comp_out,
    output reg [3:0] switch_port_out
);
`include "pll_synth_regs.vh"

////////////////////////////////////////////////////////////////////////
// Helpers

function [31:0] merge_bytes;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] sel;
    integer i;
    begin
        merge_bytes = old_val;
        for (i = 0; i < 4; i = i + 1) begin
            if (sel[i]) begin
                merge_bytes[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
    end
endfunction

function [8:0] ref_ratio;
    input [3:0] code;
    begin
        case (code)
            4'h0: ref_ratio = 9'h002;
            4'h1: ref_ratio = 9'h004;
            4'h2: ref_ratio = 9'h008;
            4'h3: ref_ratio = 9'h010;
            4'h4: ref_ratio = 9'h020;
            4'h5: ref_ratio = 9'h040;
            4'h6: ref_ratio = 9'h080;
            4'h7: ref_ratio = 9'h100;
            4'h9: ref_ratio = 9'h006;
            4'ha: ref_ratio = 9'h00c;
            4'hb: ref_ratio = 9'h018;
            4'hc: ref_ratio = 9'h030;
            4'hd: ref_ratio = 9'h060;
            4'he: ref_ratio = 9'h0c0;
            4'hf: ref_ratio = 9'h180;
            default: ref_ratio = 9'h000;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////
// Registers

reg [16:0] ratio_reg;
reg [`CFG_WIDTH-1:0] config_reg;
reg [3:0] port_data_reg;
wire [31:0] ratio_merged;
wire [31:0] config_merged;
wire [31:0] port_merged;
wire bus_req;
wire prescaler_on_bit;
wire [3:0] ref_ratio_select;
wire ref_out_on_bit;
wire out_select_bit;
wire [2:0] test_function_select;
wire ext_ref_select;
wire test_mode;
wire ratio_low;
wire ref_code_bad;
reg [31:0] read_mux;

assign bus_req = wb_cyc_in & wb_stb_in;
assign ratio_merged = merge_bytes({15'h0000, ratio_reg}, wb_dat_in, wb_sel_in);
assign config_merged = merge_bytes({21'h000000, config_reg}, wb_dat_in, wb_sel_in);
assign port_merged = merge_bytes({28'h0000000, port_data_reg}, wb_dat_in, wb_sel_in);

assign prescaler_on_bit = config_reg[`CFG_PRESCALER_ON];
assign ref_ratio_select = config_reg[`CFG_REF_RATIO_MSB:`CFG_REF_RATIO_LSB];
assign ref_out_on_bit = config_reg[`CFG_REF_OUT_ON];
assign out_select_bit = config_reg[`CFG_OUT_SELECT];
assign test_function_select = config_reg[`CFG_TEST_SEL_MSB:`CFG_TEST_SEL_LSB];
assign ext_ref_select = config_reg[`CFG_EXT_REF_SEL];

// Test functions only act with the reference output off
assign test_mode = ~ref_out_on_bit & out_select_bit;

// Below 240 the A count can outrun M, so the ratio is not 16*M+A
assign ratio_low = (ratio_reg < `RATIO_MIN);
assign ref_code_bad = (ref_ratio_select == `REF_CODE_FORBIDDEN);

// Bus writes land at the edge where the master sees ack
always @(posedge sys_clk_in) begin
    if (!rstn_in) begin
        ratio_reg <= `RATIO_RESET;
        config_reg <= `CONFIG_RESET;
        port_data_reg <= `PORT_RESET;
    end else if (bus_req & wb_ack_out & wb_we_in) begin
        case (wb_adr_in)
            `ADDR_DIVIDE_RATIO: begin
                ratio_reg <= ratio_merged[16:0];
            end
            `ADDR_CONFIG: begin
                config_reg <= config_merged[`CFG_WIDTH-1:0];
            end
            `ADDR_PORT_DATA: begin
                port_data_reg <= port_merged[3:0];
            end
            default: begin
                port_data_reg <= port_data_reg;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////
// Pin synchronisers

reg [2:0] rf_sync_reg;
reg [2:0] xtal_sync_reg;
reg [2:0] ext_sync_reg;
wire rf_edge;
wire ref_edge;
wire ref_level;

// Stage 0 feeds stage 1 only; edges compare stages 1 and 2
always @(posedge sys_clk_in) begin
    if (!rstn_in) begin
        rf_sync_reg <= 3'h0;
        xtal_sync_reg <= 3'h0;
        ext_sync_reg <= 3'h0;
    end else begin
        rf_sync_reg <= {rf_sync_reg[1:0], rf_in};
        xtal_sync_reg <= {xtal_sync_reg[1:0], xtal_osc_in};
        ext_sync_reg <= {ext_sync_reg[1:0], ext_ref_in};
    end
end

assign rf_edge = rf_sync_reg[1] & ~rf_sync_reg[2];
// Pins sampled at 25 MHz, so edges above half that rate are lost
assign ref_edge = ext_ref_select ? (ext_sync_reg[1] & ~ext_sync_reg[2]) :
                  (xtal_sync_reg[1] & ~xtal_sync_reg[2]);
assign ref_level = ext_ref_select ? ext_sync_reg[2] : xtal_sync_reg[2];

////////////////////////////////////////////////////////////////////////
// RF path: optional halving stage ahead of the programmable divider

reg halve_reg;
reg div_en_reg;
reg fpd_half_reg;
wire div_pulse;

always @(posedge sys_clk_in) begin
    if (!rstn_in) begin
        halve_reg <= 1'b0;
        div_en_reg <= 1'b0;
    end else begin
        div_en_reg <= 1'b0;
        if (rf_edge) begin
            if (prescaler_on_bit) begin
                halve_reg <= ~halve_reg;
                div_en_reg <= halve_reg;
            end else begin
                halve_reg <= 1'b0;
                div_en_reg <= 1'b1;
            end
        end
    end
end

dual_modulus_divider rf_divider (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .count_en_in(div_en_reg),
    .ratio_in(ratio_reg),
    .div_pulse_out(div_pulse)
);

always @(posedge sys_clk_in) begin
    if (!rstn_in) begin
        fpd_half_reg <= 1'b0;
    end else if (div_pulse) begin
        fpd_half_reg <= ~fpd_half_reg;
    end
end

////////////////////////////////////////////////////////////////////////
// Reference divider

reg [8:0] ref_cnt_reg;
reg comp_pulse_reg;
reg comp_half_reg;
wire [8:0] ref_top;

assign ref_top = ref_ratio(ref_ratio_select) - 9'h001;

// Forbidden code stops the comparison clock rather than guessing a ratio
always @(posedge sys_clk_in) begin
    if (!rstn_in) begin
        ref_cnt_reg <= 9'h000;
        comp_pulse_reg <= 1'b0;
        comp_half_reg <= 1'b0;
    end else begin
        comp_pulse_reg <= 1'b0;
        if (ref_code_bad) begin
            ref_cnt_reg <= 9'h000;
        end else if (ref_edge) begin
            if (ref_cnt_reg >= ref_top) begin
                ref_cnt_reg <= 9'h000;
                comp_pulse_reg <= 1'b1;
                comp_half_reg <= ~comp_half_reg;
            end else begin
                ref_cnt_reg <= ref_cnt_reg + 9'h001;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Phase/frequency comparator and charge pump

localparam PFD_IDLE = 3'b001;
localparam PFD_UP = 3'b010;
localparam PFD_DOWN = 3'b100;

reg [2:0] pfd_state_reg;
reg [2:0] pfd_state_next;

always @* begin
    pfd_state_next = pfd_state_reg;
    case (pfd_state_reg)
        PFD_IDLE: begin
            if (comp_pulse_reg & ~div_pulse) begin
                pfd_state_next = PFD_UP;
            end else if (div_pulse & ~comp_pulse_reg) begin
                pfd_state_next = PFD_DOWN;
            end
        end
        PFD_UP: begin
            if (div_pulse) begin
                pfd_state_next = PFD_IDLE;
            end
        end
        PFD_DOWN: begin
            if (comp_pulse_reg) begin
                pfd_state_next = PFD_IDLE;
            end
        end
        default: begin
            pfd_state_next = PFD_IDLE;
        end
    endcase
end

always @(posedge sys_clk_in) begin
    if (!rstn_in) begin
        pfd_state_reg <= PFD_IDLE;
    end else begin
        pfd_state_reg <= pfd_state_next;
    end
end

////////////////////////////////////////////////////////////////////////
// Output pins

wire pump_off;
wire varactor_off;
wire fpd_to_port;

assign pump_off = test_mode & test_function_select[`TEST_PUMP_OFF];
assign varactor_off = test_mode & test_function_select[`TEST_VARACTOR_OFF];
assign fpd_to_port = test_mode & test_function_select[`TEST_FPD_TO_PORT];

always @(posedge sys_clk_in) begin
    if (!rstn_in) begin
        pump_up_out <= 1'b0;
        pump_down_out <= 1'b0;
        pump_oe_out <= 1'b0;
        varactor_drive_on_out <= 1'b0;
        ref_comp_out <= 1'b1;
        switch_port_out <= `PORT_RESET;
    end else begin
        pump_up_out <= ~pump_off & (pfd_state_next == PFD_UP);
        pump_down_out <= ~pump_off & (pfd_state_next == PFD_DOWN);
        pump_oe_out <= ~pump_off;
        varactor_drive_on_out <= ~varactor_off;
        // Disabled output idles high; software turns it off when unused
        if (!ref_out_on_bit) begin
            ref_comp_out <= 1'b1;
        end else if (out_select_bit) begin
            ref_comp_out <= comp_half_reg;
        end else begin
            ref_comp_out <= ref_level;
        end
        // Port data stays stored while port zero carries the test signal
        switch_port_out <= {port_data_reg[3:1], fpd_to_port ? fpd_half_reg : port_data_reg[0]};
    end
end

////////////////////////////////////////////////////////////////////////
// Bus answer

always @* begin
    read_mux = 32'h00000000;
    case (wb_adr_in)
        `ADDR_DIVIDE_RATIO: begin
            read_mux = {15'h0000, ratio_reg};
        end
        `ADDR_CONFIG: begin
            read_mux = {21'h000000, config_reg};
        end
        `ADDR_PORT_DATA: begin
            read_mux = {28'h0000000, port_data_reg};
        end
        `ADDR_STATUS: begin
            read_mux[`STAT_RATIO_LOW] = ratio_low;
            read_mux[`STAT_REF_CODE_BAD] = ref_code_bad;
            read_mux[`STAT_PUMP_UP] = (pfd_state_reg == PFD_UP);
            read_mux[`STAT_PUMP_DOWN] = (pfd_state_reg == PFD_DOWN);
            read_mux[`STAT_TEST_MODE] = test_mode;
            read_mux[`STAT_FPD_HALF] = fpd_half_reg;
        end
        default: begin
            read_mux = 32'h00000000;
        end
    endcase
end

// One wait state; unmapped addresses answer with zero data
always @(posedge sys_clk_in) begin
    if (!rstn_in) begin
        wb_ack_out <= 1'b0;
        wb_dat_out <= 32'h00000000;
    end else begin
        wb_ack_out <= bus_req & ~wb_ack_out;
        if (bus_req & ~wb_ack_out) begin
            wb_dat_out <= read_mux;
        end
    end
end

endmodule

// ---- verilog/pll_synth_regs.vh ----
`ifndef PLL_SYNTH_REGS_VH
`define PLL_SYNTH_REGS_VH

////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define ADDR_DIVIDE_RATIO 8'h00
`define ADDR_CONFIG 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_PORT_DATA 8'h0c

////////////////////////////////////////////////////////////////////////
// Config field positions
`define CFG_PRESCALER_ON 0
`define CFG_REF_RATIO_LSB 1
`define CFG_REF_RATIO_MSB 4
`define CFG_REF_OUT_ON 5
`define CFG_OUT_SELECT 6
`define CFG_TEST_SEL_LSB 7
`define CFG_TEST_SEL_MSB 9
`define CFG_EXT_REF_SEL 10
`define CFG_WIDTH 11

// Test function select bits
`define TEST_VARACTOR_OFF 0
`define TEST_PUMP_OFF 1
`define TEST_FPD_TO_PORT 2

// Status field positions
`define STAT_RATIO_LOW 0
`define STAT_REF_CODE_BAD 1
`define STAT_PUMP_UP 2
`define STAT_PUMP_DOWN 3
`define STAT_TEST_MODE 4
`define STAT_FPD_HALF 5

////////////////////////////////////////////////////////////////////////
// Reset values and limits
`define RATIO_RESET 17'h000f0
`define CONFIG_RESET 11'h066
`define PORT_RESET 4'h0
`define RATIO_MIN 17'h000f0
`define REF_CODE_FORBIDDEN 4'h8
`define DM_LOW_TOP 5'h0f
`define DM_HIGH_TOP 5'h10

`endif

// ---- verilog/dual_modulus_divider.v ----
`timescale 1ns/1ps
module dual_modulus_divider (
    // Clock and reset
    input wire sys_clk_in,
    input wire rstn_in,
    // Input edges and ratio
    input wire count_en_in,
    input wire [16:0] ratio_in,
    // Divided output
    output reg div_pulse_out
);
`include "pll_synth_regs.vh"

reg [4:0] pre_cnt_reg;
reg [3:0] a_cnt_reg;
reg [12:0] m_cnt_reg;
wire dual_top;

// Modulus 17 while A remains, 16 afterwards
assign dual_top = (a_cnt_reg != 4'h0) ? (pre_cnt_reg == `DM_HIGH_TOP) : (pre_cnt_reg == `DM_LOW_TOP);

always @(posedge sys_clk_in) begin
    if (!rstn_in) begin
        pre_cnt_reg <= 5'h00;
        a_cnt_reg <= 4'h0;
        m_cnt_reg <= 13'h0000;
        div_pulse_out <= 1'b0;
    end else begin
        div_pulse_out <= 1'b0;
        if (count_en_in) begin
            if (dual_top) begin
                pre_cnt_reg <= 5'h00;
                // Ratio only reloads at a period end, so a change never tears a cycle
                if (m_cnt_reg <= 13'h0001) begin
                    m_cnt_reg <= ratio_in[16:4];
                    a_cnt_reg <= ratio_in[3:0];
                    div_pulse_out <= 1'b1;
                end else begin
                    m_cnt_reg <= m_cnt_reg - 13'h0001;
                    if (a_cnt_reg != 4'h0) begin
                        a_cnt_reg <= a_cnt_reg - 4'h1;
                    end
                end
            end else begin
                pre_cnt_reg <= pre_cnt_reg + 5'h01;
            end
        end
    end
end

endmodule

// ---- verilog/dummy_unused_marker.v ----
`timescale 1ns/1ps

// ---- test/pll_synth_divider_core_sva.sv ----
`timescale 1ns/1ps
`include "pll_synth_regs.vh"
module pll_synth_divider_core_sva (
    // Clock and reset
    input wire sys_clk_in,
    input wire rstn_in,
    // Bus
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire [7:0] wb_adr_in,
    input wire [3:0] wb_sel_in,
    input wire [31:0] wb_dat_in,
    input wire [31:0] wb_dat_out,
    input wire wb_ack_out,
    // Pins
    input wire pump_up_out,
    input wire pump_down_out,
    input wire pump_oe_out,
    input wire varactor_drive_on_out,
    input wire ref_comp_out,
    input wire [3:0] switch_port_out
);
    logic [10:0] cfg_reg;
    logic [3:0] port_reg;
    logic [1:0] age_reg;
    wire wr = wb_cyc_in & wb_stb_in & wb_ack_out & wb_we_in;
    wire tm = !cfg_reg[`CFG_REF_OUT_ON] && cfg_reg[`CFG_OUT_SELECT];
    wire [2:0] ts = cfg_reg[`CFG_TEST_SEL_MSB:`CFG_TEST_SEL_LSB];
    // Outputs lag a write by a register stage, so wait two edges
    wire settled = age_reg >= 2'd2;
    always @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            cfg_reg <= `CONFIG_RESET;
            port_reg <= `PORT_RESET;
            age_reg <= 2'd0;
        end else begin
            if (wr && wb_adr_in == `ADDR_CONFIG && wb_sel_in[0]) cfg_reg[7:0] <= wb_dat_in[7:0];
            if (wr && wb_adr_in == `ADDR_CONFIG && wb_sel_in[1]) cfg_reg[10:8] <= wb_dat_in[10:8];
            if (wr && wb_adr_in == `ADDR_PORT_DATA && wb_sel_in[0]) port_reg <= wb_dat_in[3:0];
            age_reg <= wr ? 2'd0 : (age_reg == 2'd3 ? age_reg : age_reg + 2'd1);
        end
    end
////////////////////////////////////////////////////////////////////////
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);
    sequence s_req;
        wb_cyc_in && wb_stb_in && !wb_ack_out;
    endsequence
    sequence s_ans;
        wb_ack_out ##1 !wb_ack_out;
    endsequence
    chk_ack_latency: assert property (s_req |=> s_ans) else $error("ack not a pulse one cycle after request");
    chk_ack_cause: assert property ($rose(wb_ack_out) |-> $past(wb_cyc_in) && $past(wb_stb_in))
        else $error("ack without request");
    chk_unmapped_zero: assert property (wb_ack_out && !wb_we_in && wb_adr_in[7:4] != 4'h0 |-> wb_dat_out == 32'h0)
        else $error("unmapped read not zero");
    chk_pump_exclusive: assert property (!(pump_up_out && pump_down_out))
        else $error("pump up and down together");
    chk_varactor_test: assert property (settled |-> varactor_drive_on_out == !(tm && ts[0]))
        else $error("varactor drive wrong for mode");
    chk_pump_hiz: assert property (settled |-> pump_oe_out == !(tm && ts[1]))
        else $error("pump enable wrong for mode");
    chk_port_route: assert property (settled && !(tm && ts[2]) |-> switch_port_out == port_reg)
        else $error("port data wrong");
    chk_ref_off_high: assert property (settled && !cfg_reg[`CFG_REF_OUT_ON] |-> ref_comp_out)
        else $error("disabled reference output not high");
endmodule
bind pll_synth_divider_core pll_synth_divider_core_sva u_sva (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .pump_up_out(pump_up_out), .pump_down_out(pump_down_out), .pump_oe_out(pump_oe_out),
    .varactor_drive_on_out(varactor_drive_on_out), .ref_comp_out(ref_comp_out),
    .switch_port_out(switch_port_out));

// ---- test/vco_model.sv ----
`timescale 1ns/1ps
module vco_model (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    // Loop controls
    input wire logic pump_up_in,
    input wire logic pump_down_in,
    input wire logic pump_oe_in,
    input wire logic drive_on_in,
    // Oscillator
    output logic rf_out
);
    logic [2:0] half_reg;
    logic [2:0] cnt_reg;
    // Half period 4..6 cycles keeps edges slower than the pin sync limit
    always @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            half_reg <= 3'h4;
            cnt_reg <= 3'h0;
            rf_out <= 1'b0;
        end else begin
            if (cnt_reg >= half_reg - 3'h1) begin
                cnt_reg <= 3'h0;
                rf_out <= ~rf_out;
            end else begin
                cnt_reg <= cnt_reg + 3'h1;
            end
            // Tuning frozen while drive is off or pump floats
            if (drive_on_in && pump_oe_in) begin
                if (pump_up_in && half_reg > 3'h4) half_reg <= half_reg - 3'h1;
                else if (pump_down_in && half_reg < 3'h6) half_reg <= half_reg + 3'h1;
            end
        end
    end
endmodule

// ---- test/pll_synth_divider_core_bench.sv ----
`timescale 1ns/1ps
`include "pll_synth_regs.vh"
module pll_synth_divider_core_bench;
    logic sys_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic wb_cyc_in = 1'b0;
    logic wb_stb_in = 1'b0;
    logic wb_we_in = 1'b0;
    logic [7:0] wb_adr_in = 8'h00;
    logic [3:0] wb_sel_in = 4'h0;
    logic [31:0] wb_dat_in = 32'h0;
    logic xtal_osc_in = 1'b0;
    logic ext_ref_in = 1'b0;
    wire rf_in;
    wire [31:0] wb_dat_out;
    wire wb_ack_out, pump_up_out, pump_down_out, pump_oe_out, varactor_drive_on_out, ref_comp_out;
    wire [3:0] switch_port_out;
    int err_total = 0;
    int cmp_count = 0;
    int rf_cnt = 0;
    int xtal_cnt = 0;
    int ext_cnt = 0;
    always #20 sys_clk_in = ~sys_clk_in;
    always @(posedge rf_in) rf_cnt++;
    // Reference sources: crystal period 6 cycles, external 10
    always @(posedge sys_clk_in) begin
        xtal_cnt <= (xtal_cnt == 2) ? 0 : xtal_cnt + 1;
        ext_cnt <= (ext_cnt == 4) ? 0 : ext_cnt + 1;
        if (xtal_cnt == 2) xtal_osc_in <= ~xtal_osc_in;
        if (ext_cnt == 4) ext_ref_in <= ~ext_ref_in;
    end
    pll_synth_divider_core u_dut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .wb_cyc_in(wb_cyc_in),
        .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
        .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .rf_in(rf_in),
        .xtal_osc_in(xtal_osc_in), .ext_ref_in(ext_ref_in), .pump_up_out(pump_up_out),
        .pump_down_out(pump_down_out), .pump_oe_out(pump_oe_out),
        .varactor_drive_on_out(varactor_drive_on_out), .ref_comp_out(ref_comp_out),
        .switch_port_out(switch_port_out));
    vco_model u_vco (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .pump_up_in(pump_up_out),
        .pump_down_in(pump_down_out), .pump_oe_in(pump_oe_out), .drive_on_in(varactor_drive_on_out),
        .rf_out(rf_in));
////////////////////////////////////////////////////////////////////////
    task conclude;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge sys_clk_in);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in <= w;
        wb_adr_in <= a;
        wb_dat_in <= d;
        wb_sel_in <= 4'hf;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (wb_ack_out !== 1'b1 && n < 50);
        if (n >= 50) begin
            $display("CHECK FAILED bus ack expected 1 seen 0");
            err_total++;
            conclude();
        end
        q = wb_dat_out;
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
        wb_we_in <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask
    function automatic logic [31:0] cfg(input logic pe, input logic [3:0] code, input logic re, input logic rs,
        input logic [2:0] ts, input logic ext);
        return {21'h0, ext, ts, rs, re, code, pe};
    endfunction
    // Waits for a change of port bit0 (s=0) or the reference pin (s=1)
    task automatic wait_tog(input logic s, output int n);
        logic v;
        v = s ? ref_comp_out : switch_port_out[0];
        n = 0;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while ((s ? ref_comp_out : switch_port_out[0]) === v && n < 9000);
        if (n >= 9000) begin
            $display("CHECK FAILED toggle expected edge seen none");
            err_total++;
            conclude();
        end
    endtask
////////////////////////////////////////////////////////////////////////
    task t_regs;
        logic [31:0] q;
        rd_chk("ratio", `ADDR_DIVIDE_RATIO, 32'h000000f0);
        rd_chk("config", `ADDR_CONFIG, 32'h00000066);
        rd_chk("port", `ADDR_PORT_DATA, 32'h00000000);
        rd_chk("unmapped", 8'h10, 32'h00000000);
        wr(`ADDR_DIVIDE_RATIO, 32'hffffffff);
        rd_chk("ratio max", `ADDR_DIVIDE_RATIO, 32'h0001ffff);
        wr(`ADDR_DIVIDE_RATIO, 32'h000000ef);
        wb(1'b0, `ADDR_STATUS, 32'h0, q);
        chk("ratio low", 32'h1, {31'h0, q[`STAT_RATIO_LOW]});
        $display("test regs done");
    endtask
    task t_tmode;
        logic [31:0] q;
        wr(`ADDR_PORT_DATA, 32'h0000000a);
        for (int t = 0; t < 9; t++) begin
            wr(`ADDR_CONFIG, cfg(1'b0, 4'h3, 1'b0, t < 8, t < 8 ? t[2:0] : 3'h7, 1'b0));
            repeat (3) @(posedge sys_clk_in);
            chk("varactor", !(t < 8 && t[0]), varactor_drive_on_out);
            chk("pump oe", !(t < 8 && t[1]), pump_oe_out);
            chk("port high", 3'h5, switch_port_out[3:1]);
            if (!(t < 8 && t[2])) chk("port bit0", 1'b0, switch_port_out[0]);
            chk("ref idle", 1'b1, ref_comp_out);
            wb(1'b0, `ADDR_STATUS, 32'h0, q);
            chk("test mode", t < 8, q[`STAT_TEST_MODE]);
        end
        $display("test modes done");
    endtask
    task t_divider;
        int a;
        int n;
        for (int i = 0; i < 3; i++) begin
            wr(`ADDR_DIVIDE_RATIO, 32'h000000f0 + (i == 1 ? 3 : 0));
            wr(`ADDR_CONFIG, cfg(i == 2, 4'h3, 1'b0, 1'b1, 3'h4, 1'b0));
            wait_tog(1'b0, n);
            wait_tog(1'b0, n);
            a = rf_cnt;
            wait_tog(1'b0, n);
            chk("rf edges", (i == 1 ? 243 : 240) * (i == 2 ? 2 : 1), rf_cnt - a);
        end
        $display("test divider done");
    endtask
    task t_refdiv;
        int n;
        wr(`ADDR_CONFIG, cfg(1'b0, 4'h0, 1'b1, 1'b1, 3'h0, 1'b0));
        wait_tog(1'b1, n);
        for (int c = 0; c < 16; c++) begin
            if (c != 8) begin
                wr(`ADDR_CONFIG, cfg(1'b0, c[3:0], 1'b1, 1'b1, 3'h0, c[0]));
                // First two toggles may straddle the switch of source or ratio
                repeat (3) wait_tog(1'b1, n);
                chk("ref cycles", (c < 8 ? 2 << c : 6 << (c - 9)) * (c[0] ? 10 : 6), n);
            end
        end
        // Select low passes the crystal level itself, three cycles per half period
        wr(`ADDR_CONFIG, cfg(1'b0, 4'h3, 1'b1, 1'b0, 3'h0, 1'b0));
        repeat (3) wait_tog(1'b1, n);
        chk("ref level", 3, n);
        $display("test reference done");
    endtask
    task t_pfd;
        int up;
        int dn;
        logic [31:0] q;
        wr(`ADDR_DIVIDE_RATIO, 32'h000000f0);
        for (int k = 0; k < 3; k++) begin
            wr(`ADDR_CONFIG, cfg(1'b0, k == 0 ? 4'h0 : (k == 1 ? 4'hf : 4'h8), 1'b0, 1'b1, 3'h1, k == 1));
            up = 0;
            dn = 0;
            repeat (3000) @(posedge sys_clk_in);
            repeat (6000) begin
                @(posedge sys_clk_in);
                up += (pump_up_out === 1'b1);
                dn += (pump_down_out === 1'b1);
            end
            chk("pump up seen", k == 0, up > 0);
            chk("pump down seen", k != 0, dn > 0);
            wb(1'b0, `ADDR_STATUS, 32'h0, q);
            chk("code bad", k == 2, q[`STAT_REF_CODE_BAD]);
        end
        $display("test compare done");
    endtask
    initial begin
        repeat (16) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        t_regs;
        t_tmode;
        t_divider;
        t_refdiv;
        t_pfd;
        conclude;
    end
endmodule
